// ### imalu_datapath.sv
/*
 Immediate-operand ALU datapath: one instruction in, one registered result a cycle later.
 Assumes the decoder issues instr with issue_valid and supplies the source register value
 read from the register file in the same cycle.
*/
`timescale 1ns/1ns
`default_nettype none
module imalu_datapath (
	input  wire logic                   mclk,         // Core clock, 10 MHz
	input  wire logic                   reset_n,      // Asynchronous reset, active low
	input  wire logic                   issue_valid,  // Instruction presented this cycle
	input  wire logic [31:0]            instr,        // Immediate-format instruction word
	input  wire logic [63:0]            source_value, // Value of the source register
	input  wire logic                   mode64,       // Core is in 64-bit mode
	output imalu_pkg::imalu_result_t    result,       // Registered writeback and trap
	output logic                        unknown_op    // Opcode not handled here
);

	imalu_pkg::imalu_instr_t fields;
	logic [63:0]             imm_sext;
	logic [63:0]             imm_zext;
	logic                    known;
	logic [31:0]             word_sum;
	logic [63:0]             dword_sum;
	logic                    word_ovf;
	logic                    dword_ovf;
	logic [63:0]             alu_value;
	logic                    trap;
	logic                    traps_enabled;
	imalu_pkg::imalu_result_t next_result;

	// ****************************************************************
	// Decode
	// ****************************************************************
	imalu_decode u_decode (
		.instr    (instr),
		.fields   (fields),
		.imm_sext (imm_sext),
		.imm_zext (imm_zext),
		.known    (known)
	);

	assign unknown_op = issue_valid & ~known;

	// ****************************************************************
	// Arithmetic and result select
	// ****************************************************************
	always_comb begin
		word_sum  = source_value[31:0] + imm_sext[31:0];  // RQ1 RQ2
		dword_sum = source_value + imm_sext;               // RQ7 RQ8
		word_ovf  = (source_value[31] == imm_sext[31]) && (word_sum[31] != source_value[31]);
		dword_ovf = (source_value[63] == imm_sext[63]) && (dword_sum[63] != source_value[63]);
		traps_enabled = 1'b1;
		alu_value = imalu_pkg::RESULT_RESET;
		trap      = 1'b0;
		case (fields.opcode)
			imalu_pkg::word_add_imm_trapping: begin
				alu_value = {{32{word_sum[31]}}, word_sum}; // RQ1
				trap      = word_ovf;                       // RQ1
			end
			imalu_pkg::word_add_imm_wrapping: begin
				alu_value = {{32{word_sum[31]}}, word_sum}; // RQ2
			end
			imalu_pkg::set_less_imm_signed: begin
				alu_value = {63'h0, ($signed(source_value) < $signed(imm_sext))}; // RQ3
			end
			imalu_pkg::set_less_imm_unsigned: begin
				alu_value = {63'h0, (source_value < imm_sext)}; // RQ4
			end
			imalu_pkg::and_with_imm: begin
				alu_value = source_value & imm_zext; // RQ5
			end
			imalu_pkg::or_with_imm: begin
				alu_value = source_value | imm_zext; // RQ5
			end
			imalu_pkg::xor_with_imm: begin
				alu_value = source_value ^ imm_zext; // RQ5
			end
			imalu_pkg::upper_half_load: begin
				alu_value = {{32{fields.imm[imalu_pkg::IMM_MSB]}}, fields.imm, 16'h0000}; // RQ6
			end
			imalu_pkg::dword_add_imm_trapping: begin
				alu_value = dword_sum; // RQ7
				trap      = dword_ovf; // RQ7
			end
			imalu_pkg::dword_add_imm_wrapping: begin
				alu_value = dword_sum; // RQ8
			end
			default: begin
				alu_value = imalu_pkg::RESULT_RESET;
				traps_enabled = 1'b0;
			end
		endcase
		// In 32-bit mode only the low word is architecturally visible; upper bits follow bit 31.
		if (!mode64 && fields.opcode != imalu_pkg::set_less_imm_signed
			&& fields.opcode != imalu_pkg::set_less_imm_unsigned) begin
			alu_value = {{32{alu_value[31]}}, alu_value[31:0]}; // RQ9
		end
		trap = trap & traps_enabled & issue_valid;

		next_result.write_en         = issue_valid & known & ~trap;  // RQ10 RQ12
		next_result.target_reg_field = issue_valid ? fields.target_reg_field
		                                           : imalu_pkg::REG_RESET; // RQ10
		next_result.data             = trap ? imalu_pkg::RESULT_RESET : alu_value; // RQ12
		next_result.overflow_trap    = trap; // RQ12
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			result <= '0;
		end else begin
			result <= next_result;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	sequence s_word_trap_ovf;
		issue_valid && fields.opcode == imalu_pkg::word_add_imm_trapping && word_ovf;
	endsequence

	sequence s_dword_trap_ovf;
		issue_valid && fields.opcode == imalu_pkg::dword_add_imm_trapping && dword_ovf;
	endsequence

	sequence s_issue_word_add;
		issue_valid && (fields.opcode == imalu_pkg::word_add_imm_trapping
		|| fields.opcode == imalu_pkg::word_add_imm_wrapping);
	endsequence

	sequence s_issue_upper;
		issue_valid && fields.opcode == imalu_pkg::upper_half_load;
	endsequence

	sequence s_issue_and;
		issue_valid && fields.opcode == imalu_pkg::and_with_imm;
	endsequence

	sequence s_issue_or;
		issue_valid && fields.opcode == imalu_pkg::or_with_imm;
	endsequence

	sequence s_issue_xor;
		issue_valid && fields.opcode == imalu_pkg::xor_with_imm;
	endsequence

	sequence s_issue_dword_wrap;
		issue_valid && fields.opcode == imalu_pkg::dword_add_imm_wrapping;
	endsequence

	sequence s_no_issue;
		!issue_valid;
	endsequence

	sequence s_issue_unknown;
		issue_valid && !known;
	endsequence

	a_word_add_trap: assert property (s_word_trap_ovf |=> result.overflow_trap && !result.write_en) // RQ1
		else $error("word trapping add overflow did not trap");
	a_word_wrap_notrap: assert property (
		issue_valid && fields.opcode == imalu_pkg::word_add_imm_wrapping
		|=> !result.overflow_trap && result.write_en) // RQ2
		else $error("wrapping word add trapped");
	a_word_sum_value: assert property (
		issue_valid && fields.opcode == imalu_pkg::word_add_imm_wrapping
		|=> result.data[31:0] == $past(source_value[31:0] + imm_sext[31:0])) // RQ2
		else $error("wrapping word add sum wrong");
	a_slt_signed: assert property (
		issue_valid && fields.opcode == imalu_pkg::set_less_imm_signed
		|=> result.data == {63'h0, $past($signed(source_value) < $signed(imm_sext))}) // RQ3
		else $error("signed less-than wrong");
	a_slt_unsigned: assert property (
		issue_valid && fields.opcode == imalu_pkg::set_less_imm_unsigned
		|=> result.data == {63'h0, $past(source_value < imm_sext)}) // RQ4
		else $error("unsigned less-than wrong");
	a_and_imm: assert property (
		issue_valid && fields.opcode == imalu_pkg::and_with_imm && mode64
		|=> result.data[63:16] == 48'h0) // RQ5
		else $error("and with immediate left upper bits set");
	a_upper_low_zero: assert property (
		issue_valid && fields.opcode == imalu_pkg::upper_half_load
		|=> result.data[15:0] == 16'h0000 && result.data[31:16] == $past(fields.imm)) // RQ6
		else $error("upper half load wrong");
	a_dword_trap: assert property ( // RQ7
		s_dword_trap_ovf |=> result.overflow_trap && !result.write_en)
		else $error("doubleword trapping add overflow did not trap");
	a_dword_wrap: assert property (
		issue_valid && fields.opcode == imalu_pkg::dword_add_imm_wrapping && mode64
		|=> result.write_en && result.data == $past(source_value + imm_sext)) // RQ8
		else $error("wrapping doubleword add wrong");
	a_target_field: assert property (
		issue_valid && known |=> result.target_reg_field == $past(instr[20:16])) // RQ10 RQ11
		else $error("target field not carried");
	a_trap_no_write: assert property (result.overflow_trap |-> !result.write_en) // RQ12
		else $error("trap with writeback");

	// ****************************************************************
	// Extension, logic and quiet-cycle checks
	// ****************************************************************
	// Word results and the upper load always carry bit 31 into the upper half.
	a_word_sext: assert property ( // RQ1 RQ2
		s_issue_word_add |=> result.data[63:32] == {32{result.data[31]}})
		else $error("word add result not sign-extended");
	a_upper_sext: assert property ( // RQ6
		s_issue_upper |=> result.data[63:32] == {32{result.data[31]}})
		else $error("upper half load not sign-extended");
	a_and_low: assert property ( // RQ5
		s_issue_and |=> result.write_en
		&& result.data[15:0] == $past(source_value[15:0] & fields.imm))
		else $error("and with immediate low bits wrong");
	a_or_low: assert property ( // RQ5
		s_issue_or |=> result.write_en
		&& result.data[15:0] == $past(source_value[15:0] | fields.imm))
		else $error("or with immediate low bits wrong");
	a_xor_low: assert property ( // RQ5
		s_issue_xor |=> result.write_en
		&& result.data[15:0] == $past(source_value[15:0] ^ fields.imm))
		else $error("xor with immediate low bits wrong");
	a_dword_wrap_quiet: assert property ( // RQ8
		s_issue_dword_wrap |=> !result.overflow_trap && result.write_en)
		else $error("wrapping doubleword add trapped");
	a_trap_data_zero: assert property ( // RQ12
		result.overflow_trap |-> result.data == imalu_pkg::RESULT_RESET)
		else $error("trapped result carries data");
	a_idle_quiet: assert property ( // RQ10
		s_no_issue |=> !result.write_en && !result.overflow_trap)
		else $error("result written without an issue");
	a_unknown_quiet: assert property ( // RQ11
		s_issue_unknown |=> !result.write_en && !result.overflow_trap)
		else $error("unknown opcode wrote or trapped");

endmodule : imalu_datapath
`default_nettype wire

// ### imalu_decode.sv
/*
 Field splitter and operand extender for immediate-format instruction words.
 Assumes the word is valid in the same cycle; purely combinational.
*/
`timescale 1ns/1ns
`default_nettype none
module imalu_decode (
	input  wire logic [31:0]         instr,     // Raw instruction word
	output imalu_pkg::imalu_instr_t  fields,    // Split fields
	output logic [63:0]              imm_sext,  // Sign-extended immediate
	output logic [63:0]              imm_zext,  // Zero-extended immediate
	output logic                     known      // Opcode is one of ours
);

	always_comb begin
		fields.opcode           = instr[imalu_pkg::OPCODE_MSB:imalu_pkg::OPCODE_LSB]; // RQ11
		fields.source_reg_field = instr[imalu_pkg::SRC_MSB:imalu_pkg::SRC_LSB];       // RQ11
		fields.target_reg_field = instr[imalu_pkg::TGT_MSB:imalu_pkg::TGT_LSB];       // RQ11
		fields.imm              = instr[imalu_pkg::IMM_MSB:imalu_pkg::IMM_LSB];       // RQ11
		imm_sext = {{48{instr[imalu_pkg::IMM_MSB]}}, instr[imalu_pkg::IMM_MSB:imalu_pkg::IMM_LSB]};
		imm_zext = {48'h0, instr[imalu_pkg::IMM_MSB:imalu_pkg::IMM_LSB]};
		case (instr[imalu_pkg::OPCODE_MSB:imalu_pkg::OPCODE_LSB])
			imalu_pkg::word_add_imm_trapping,  imalu_pkg::word_add_imm_wrapping,
			imalu_pkg::set_less_imm_signed,    imalu_pkg::set_less_imm_unsigned,
			imalu_pkg::and_with_imm,           imalu_pkg::or_with_imm,
			imalu_pkg::xor_with_imm,           imalu_pkg::upper_half_load,
			imalu_pkg::dword_add_imm_trapping, imalu_pkg::dword_add_imm_wrapping: known = 1'b1;
			default: known = 1'b0;
		endcase
	end

endmodule : imalu_decode
`default_nettype wire

// ### imalu_pkg.sv
/*
 Constants, operation codes and carrier types for the immediate-operand ALU datapath.
 Assumes a single core clock domain and an upstream decoder that presents one instruction per cycle.
*/
// How it works
// RQ1: Trapping word add: sign-extend immediate, 32-bit sum, extend result, trap on overflow.
// RQ2: Wrapping word add: same 32-bit extended sum, never traps.
// RQ3: Signed less-than: sign-extended immediate, signed compare, result 1 or 0.
// RQ4: Unsigned less-than: sign-extended immediate, unsigned compare, result 1 or 0.
// RQ5: And, or, xor with zero-extended immediate, bitwise, written to target.
// RQ6: Upper load: immediate into bits 31..16, low half zero, extended in 64-bit mode.
// RQ7: Trapping doubleword add: 64-bit sum, trap on signed overflow.
// RQ8: Wrapping doubleword add: same 64-bit sum, never traps.
// RQ9: Software supplies sign-extended 32-bit operands; otherwise word results are undefined.
// RQ10: One operand from source field, other from immediate; result goes to target field.
// RQ11: Opcode bits 31..26, source 25..21, target 20..16, immediate 15..0.
// RQ12: On overflow trap the target is not written; the exception is flagged instead.
package imalu_pkg;

	// ****************************************************************
	// Instruction field layout
	// ****************************************************************
	localparam int OPCODE_MSB = 31;
	localparam int OPCODE_LSB = 26;
	localparam int SRC_MSB    = 25;
	localparam int SRC_LSB    = 21;
	localparam int TGT_MSB    = 20;
	localparam int TGT_LSB    = 16;
	localparam int IMM_MSB    = 15;
	localparam int IMM_LSB    = 0;
	localparam int WORD_MSB   = 31;
	localparam int UPPER_LSB  = 16;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [63:0] RESULT_RESET = 64'h0000_0000_0000_0000;
	localparam logic [4:0]  REG_RESET    = 5'h00;

	// ****************************************************************
	// Primary opcodes
	// ****************************************************************
	typedef enum logic [5:0] {
		word_add_imm_trapping  = 6'h08,
		word_add_imm_wrapping  = 6'h09,
		set_less_imm_signed    = 6'h0a,
		set_less_imm_unsigned  = 6'h0b,
		and_with_imm           = 6'h0c,
		or_with_imm            = 6'h0d,
		xor_with_imm           = 6'h0e,
		upper_half_load        = 6'h0f,
		dword_add_imm_trapping = 6'h18,
		dword_add_imm_wrapping = 6'h19
	} imalu_op_t;

	// ****************************************************************
	// Carriers
	// ****************************************************************
	typedef struct packed {
		logic [5:0] opcode;
		logic [4:0] source_reg_field;
		logic [4:0] target_reg_field;
		logic [15:0] imm;
	} imalu_instr_t;

	typedef struct packed {
		logic        write_en;
		logic [4:0]  target_reg_field;
		logic [63:0] data;
		logic        overflow_trap;
	} imalu_result_t;

endpackage : imalu_pkg

// ### imalu_regfile_model.sv
/*
 Register file stand-in on the far side of the datapath's operand port.
 Assumes the bench preloads each source value through the load port.
*/
`timescale 1ns/1ns
`default_nettype none
module imalu_regfile_model (
	input  wire logic        mclk,        // Core clock
	input  wire logic        load_en,     // Preload strobe
	input  wire logic [4:0]  load_idx,    // Register to preload
	input  wire logic [63:0] load_data,   // Value to preload
	input  wire logic [31:0] instr,       // Word being issued
	output logic      [63:0] source_value // Read port
);
	logic [63:0] regs [32];
	always_ff @(posedge mclk) begin
		if (load_en) begin
			regs[load_idx] <= load_data;
		end
	end
	// A same-cycle preload is bypassed so operands can be issued back to back.
	assign source_value = (load_en && load_idx == instr[25:21]) ?
		load_data : regs[instr[25:21]];
endmodule : imalu_regfile_model
`default_nettype wire

// ### immediate_alu_datapath_test.sv
/*
 Self-checking bench for the immediate-operand datapath.
 Assumes the one-cycle registered answer and combinational unknown_op.
*/
`timescale 1ns/1ns
`default_nettype none
module immediate_alu_datapath_test;
	logic                     mclk = 1'b0;
	logic                     reset_n = 1'b0;
	logic                     issue_valid = 1'b0;
	logic                     mode64 = 1'b1;
	logic                     load_en = 1'b0;
	logic [4:0]               load_idx = 5'h07;
	logic [63:0]              load_data = 64'h0;
	logic [31:0]              instr = 32'h0;
	logic [63:0]              source_value;
	logic                     unknown_op;
	imalu_pkg::imalu_result_t result;
	imalu_pkg::imalu_result_t pend = '0;
	logic                     pend_unk = 1'b0;
	int                       num_errors = 0;
	int                       n_compared = 0;
	logic [5:0]               ops [10] = '{6'h08, 6'h09, 6'h0a, 6'h0b, 6'h0c,
		6'h0d, 6'h0e, 6'h0f, 6'h18, 6'h19};

	always #50 mclk = ~mclk;

	imalu_regfile_model rf_u (.mclk(mclk), .load_en(load_en), .load_idx(load_idx),
		.load_data(load_data), .instr(instr), .source_value(source_value));
	imalu_datapath dut_u (.mclk(mclk), .reset_n(reset_n), .issue_valid(issue_valid),
		.instr(instr), .source_value(source_value), .mode64(mode64), .result(result),
		.unknown_op(unknown_op));

	task check(input logic [70:0] seen, input logic [70:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Compares the answer of the previous issue; unknown opcodes only promise no write or trap.
	task check_pend;
		if (pend_unk) begin
			check({69'h0, result.write_en, result.overflow_trap}, 71'h0);
		end else begin
			check(result, pend);
		end
	endtask : check_pend

	task run(input logic [5:0] op, input logic [63:0] s, input logic [15:0] imm);
		logic [63:0] sx, d;
		logic [31:0] w;
		logic        ov, known, trap;
		@(posedge mclk);
		issue_valid <= 1'b1;
		load_en <= 1'b1;
		load_data <= s;
		instr <= {op, 5'h07, op[4:0] ^ 5'h15, imm};
		#1;
		check_pend();
		sx = {{48{imm[15]}}, imm};
		w = s[31:0] + sx[31:0];
		ov = 1'b0;
		d = 64'h0;
		known = 1'b1;
		case (op)
			6'h08, 6'h09: begin
				d = {32'h0, w};
				ov = (s[31] == sx[31]) && (w[31] != s[31]);
			end
			6'h0a: d = {63'h0, $signed(s) < $signed(sx)};
			6'h0b: d = {63'h0, s < sx};
			6'h0c: d = s & {48'h0, imm};
			6'h0d: d = s | {48'h0, imm};
			6'h0e: d = s ^ {48'h0, imm};
			6'h0f: d = {32'h0, imm, 16'h0};
			6'h18, 6'h19: begin
				d = s + sx;
				ov = (s[63] == sx[63]) && (d[63] != s[63]);
			end
			default: known = 1'b0;
		endcase
		if (op inside {6'h08, 6'h09, 6'h0f} || (!mode64 && !(op inside {6'h0a, 6'h0b}))) begin
			d = {{32{d[31]}}, d[31:0]};
		end
		trap = ov && (op == 6'h08 || op == 6'h18);
		check({70'h0, unknown_op}, {70'h0, !known});
		pend = {known && !trap, op[4:0] ^ 5'h15, trap ? 64'h0 : d, trap};
		pend_unk = !known;
	endtask : run

	task idle;
		@(posedge mclk);
		issue_valid <= 1'b0;
		load_en <= 1'b0;
		// An opcode outside the set keeps the registered data at zero while idle.
		instr <= 32'h00e0_0000;
		#1;
		check_pend();
		pend = '0;
		pend_unk = 1'b0;
	endtask : idle

	task t_ops;
		foreach (ops[i]) run(ops[i], 64'hffff_ffff_8000_1234, 16'h8001);
		foreach (ops[i]) run(ops[i], 64'h0000_0000_0000_7ffe, 16'h0002);
		idle();
		$display("t_ops done");
	endtask : t_ops

	task t_ovf;
		run(6'h08, 64'h0000_0000_7fff_ffff, 16'h0001);
		run(6'h09, 64'h0000_0000_7fff_ffff, 16'h0001);
		run(6'h08, 64'hffff_ffff_8000_0000, 16'hffff);
		run(6'h18, 64'h7fff_ffff_ffff_ffff, 16'h0001);
		run(6'h19, 64'h7fff_ffff_ffff_ffff, 16'h0001);
		run(6'h18, 64'h8000_0000_0000_0000, 16'h8000);
		run(6'h18, 64'h0000_0000_7fff_ffff, 16'h0001);
		idle();
		$display("t_ovf done");
	endtask : t_ovf

	task t_mode32;
		@(posedge mclk);
		mode64 <= 1'b0;
		foreach (ops[i]) run(ops[i], 64'hffff_ffff_8765_4321, 16'h9abc);
		idle();
		mode64 <= 1'b1;
		$display("t_mode32 done");
	endtask : t_mode32

	task t_unknown;
		run(6'h00, 64'h1, 16'h1);
		run(6'h3f, 64'h1, 16'h1);
		run(6'h0d, 64'h1, 16'h00f0);
		idle();
		idle();
		$display("t_unknown done");
	endtask : t_unknown

	task end_sim;
		$display("Compared %0d, errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_sim

	initial begin
		#(2000 * 100);
		num_errors++;
		end_sim();
	end

	initial begin
		repeat (20) @(posedge mclk);
		reset_n <= 1'b1;
		t_ops();
		t_ovf();
		t_mode32();
		t_unknown();
		end_sim();
	end
endmodule : immediate_alu_datapath_test
`default_nettype wire
